// ==== hdl/eip_event_irq.sv ====
// Event flags, interrupt request pin and datapath pattern checker.
`timescale 1ns/100ps
//Contract
//- Interrupt request pin is open-drain, active low: pulled low or released.
//- Pin pulled low while any latched flag is set, released otherwise.
//- Enabled event sets its flag on a rising edge; disabled flag stays zero.
//- A flag clears only by its clear write, by writing its enable to zero, or by device reset.
//- Flag readback returns raw event or latched flag per readback select.
//- Up to 48 and more monitored events across several register blocks.
//- Per-chip block: latched flag when enabled, live event when disabled.
//- Per-link and lane blocks: latched flag when enabled, zero otherwise.
//- Per-chip enables at 0x01F-0x021; clears and readback at 0x023-0x025.
//- Link enables and readback at 0x47A; clears at 0x46D through 0x473.
//- Single link event: flag and clear at 0x47B bit 4, enable bit 3.
//- Per-chip readback shows live event state for disabled events, the latched flag for enabled ones.
//- Checker runs only at interpolation factor two, four or eight.
//- Control bit 2 selects the 7-bit or the 15-bit pattern.
//- Bits [1:0] = 11 enable and reset; 01 enable and run; wait 500 ms.
//- Bits 6 and 7 read zero after an I or Q error, matching fail events.
//- I error count reads at 0x14C, Q error count at 0x14D.
//- Compare 32-bit groups, at most one error counted per group.
//- Checker fail signals are per-chip events enabled by 0x020 bits [1:0].
module eip_event_irq (
  input wire logic clock,
  input wire logic rst,
  input wire logic [eip_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [eip_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [eip_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic [eip_pkg::CHIP_EVTS-1:0] chip_event,
  input wire logic [eip_pkg::LINK_EVTS-1:0] link_event,
  input wire logic link_single_event,
  input wire logic [3:0] interp_factor,
  input eip_pkg::eip_iq_type iq,
  output logic irq_n_out,
  output logic irq_n_oe_n
);

  localparam int CE = eip_pkg::CHIP_EVTS;
  localparam int LE = eip_pkg::LINK_EVTS;
  localparam int RW = eip_pkg::REG_W;

  typedef struct packed {
    logic [CE-1:0] chip_en;
    logic [CE-1:0] chip_flag;
    logic [CE-1:0] chip_prev;
    logic [eip_pkg::LINK_REGS-1:0] link_en;
    logic [LE-1:0] link_flag;
    logic [LE-1:0] link_prev;
    logic single_en;
    logic single_flag;
    logic single_prev;
    logic prbs_run;
    logic prbs_clear;
    logic prbs_sel;
    logic ack;
    logic [eip_pkg::DATA_W-1:0] rdata;
  } eip_irq_state_type;

  eip_irq_state_type st_reg;
  eip_irq_state_type st_next;

  logic [eip_pkg::IDX_W-1:0] idx;
  logic req;
  logic done;
  logic wr;
  logic [RW-1:0] wb;
  logic [CE-1:0] chip_live;
  logic [CE-1:0] chip_clr;
  logic [LE-1:0] link_clr;
  logic [RW-1:0] rmux;
  logic interp_ok;
  eip_pkg::eip_prbs_cfg_type prbs_cfg;
  logic pass_i;
  logic pass_q;
  logic [eip_pkg::ERR_CNT_W-1:0] err_i;
  logic [eip_pkg::ERR_CNT_W-1:0] err_q;

  // Index match against the k-th register of a block.
  function automatic logic idx_hit(
    input logic [eip_pkg::IDX_W-1:0] at,
    input logic [eip_pkg::IDX_W-1:0] base,
    input int k
  );
    idx_hit = (at == base + eip_pkg::IDX_W'(k));
  endfunction

  // Set wins over a clear in the same cycle, so no edge on an enabled event is lost.
  function automatic logic flag_next(
    input logic flag,
    input logic prev,
    input logic live,
    input logic en,
    input logic clr
  );
    logic rise;
    rise = live & ~prev;
    flag_next = en & (rise | (flag & ~clr));
  endfunction

  assign idx = address[eip_pkg::ADDR_W-1:2];
  assign req = read | write;
  assign done = req & st_reg.ack;
  assign wr = write & done & byteenable[0];
  assign wb = writedata[RW-1:0];

  assign interp_ok = (interp_factor == eip_pkg::INTERP_X2) ||
                     (interp_factor == eip_pkg::INTERP_X4) ||
                     (interp_factor == eip_pkg::INTERP_X8);

  // The checker does not run outside the valid interpolation factors; a clear still acts.
  always_comb begin
    prbs_cfg.clear = st_reg.prbs_run & st_reg.prbs_clear;
    prbs_cfg.run = st_reg.prbs_run & ~st_reg.prbs_clear &
                   interp_ok;
    prbs_cfg.sel15 = st_reg.prbs_sel;
  end

  eip_prbs_chk #(
    .GROUP_W(eip_pkg::GROUP_W),
    .CNT_W(eip_pkg::ERR_CNT_W)
  ) u_chk_i (
    .clock(clock),
    .rst(rst),
    .cfg(prbs_cfg),
    .valid(iq.valid),
    .data(iq.i_data),
    .pass(pass_i),
    .err_count(err_i)
  );

  eip_prbs_chk #(
    .GROUP_W(eip_pkg::GROUP_W),
    .CNT_W(eip_pkg::ERR_CNT_W)
  ) u_chk_q (
    .clock(clock),
    .rst(rst),
    .cfg(prbs_cfg),
    .valid(iq.valid),
    .data(iq.q_data),
    .pass(pass_q),
    .err_count(err_q)
  );

  // Checker failures join the per-chip events in the enable byte 0x020.
  always_comb begin
    chip_live = chip_event;
    chip_live[eip_pkg::FAIL_EVT_I] = ~pass_i;
    chip_live[eip_pkg::FAIL_EVT_Q] = ~pass_q;
  end

  // Write-one clear strobes, one register of flags per index.
  always_comb begin
    chip_clr = '0;
    link_clr = '0;
    for (int k = 0; k < eip_pkg::CHIP_REGS; k++) begin
      if (wr && idx_hit(idx, eip_pkg::IDX_CHIP_CLR0, k)) begin
        chip_clr[k*RW +: RW] = wb;
      end
    end
    for (int k = 0; k < eip_pkg::LINK_REGS; k++) begin
      if (wr && idx_hit(idx, eip_pkg::IDX_LINK_CLR0, k)) begin
        link_clr[k*RW +: RW] = wb;
      end
    end
  end

  // Read multiplexer, sampled live one cycle before the answer.
  always_comb begin
    rmux = '0;
    for (int k = 0; k < eip_pkg::CHIP_REGS; k++) begin
      if (idx_hit(idx, eip_pkg::IDX_CHIP_EN0, k)) begin
        rmux = st_reg.chip_en[k*RW +: RW];
      end
      if (idx_hit(idx, eip_pkg::IDX_CHIP_CLR0, k)) begin
        for (int b = 0; b < RW; b++) begin
          // Readback select follows the enable in this block.
          rmux[b] = st_reg.chip_en[k*RW+b] ?
                    st_reg.chip_flag[k*RW+b] :
                    chip_live[k*RW+b];
        end
      end
    end
    if (idx == eip_pkg::IDX_LINK_EN) begin
      for (int k = 0; k < eip_pkg::LINK_REGS; k++) begin
        // Disabled flags are already zero, so the select is fixed at one.
        rmux[k] = |st_reg.link_flag[k*RW +: RW];
      end
    end
    if (idx == eip_pkg::IDX_LINK_SINGLE) begin
      rmux[eip_pkg::SINGLE_EN_BIT] = st_reg.single_en;
      rmux[eip_pkg::SINGLE_FLAG_BIT] = st_reg.single_flag;
    end
    if (idx == eip_pkg::IDX_PRBS_CTRL) begin
      rmux[eip_pkg::PRBS_RUN_BIT] = st_reg.prbs_run;
      rmux[eip_pkg::PRBS_CLEAR_BIT] = st_reg.prbs_clear;
      rmux[eip_pkg::PRBS_SEL_BIT] = st_reg.prbs_sel;
      rmux[eip_pkg::PRBS_PASS_I_BIT] = pass_i;
      rmux[eip_pkg::PRBS_PASS_Q_BIT] = pass_q;
    end
    if (idx == eip_pkg::IDX_PRBS_ERR_I) begin
      rmux = err_i;
    end
    if (idx == eip_pkg::IDX_PRBS_ERR_Q) begin
      rmux = err_q;
    end
  end

  always_comb begin
    st_next = st_reg;
    // Every access takes exactly one wait cycle.
    st_next.ack = req & ~st_reg.ack;
    if (read && !st_reg.ack) begin
      st_next.rdata = {{(eip_pkg::DATA_W-RW){1'b0}}, rmux};
    end

    // Configuration writes.
    for (int k = 0; k < eip_pkg::CHIP_REGS; k++) begin
      if (wr && idx_hit(idx, eip_pkg::IDX_CHIP_EN0, k)) begin
        st_next.chip_en[k*RW +: RW] = wb;
      end
    end
    if (wr && idx == eip_pkg::IDX_LINK_EN) begin
      st_next.link_en = wb[eip_pkg::LINK_REGS-1:0];
    end
    if (wr && idx == eip_pkg::IDX_LINK_SINGLE) begin
      st_next.single_en = wb[eip_pkg::SINGLE_EN_BIT];
    end
    if (wr && idx == eip_pkg::IDX_PRBS_CTRL) begin
      st_next.prbs_run = wb[eip_pkg::PRBS_RUN_BIT];
      st_next.prbs_clear = wb[eip_pkg::PRBS_CLEAR_BIT];
      st_next.prbs_sel = wb[eip_pkg::PRBS_SEL_BIT];
    end

    // Edge history and latched flags.
    st_next.chip_prev = chip_live;
    st_next.link_prev = link_event;
    st_next.single_prev = link_single_event;
    for (int b = 0; b < CE; b++) begin
      st_next.chip_flag[b] = flag_next(st_reg.chip_flag[b],
        st_reg.chip_prev[b], chip_live[b], st_reg.chip_en[b],
        chip_clr[b]);
    end
    for (int b = 0; b < LE; b++) begin
      st_next.link_flag[b] = flag_next(st_reg.link_flag[b],
        st_reg.link_prev[b], link_event[b], st_reg.link_en[b/RW],
        link_clr[b]);
    end
    st_next.single_flag = flag_next(st_reg.single_flag,
      st_reg.single_prev, link_single_event, st_reg.single_en,
      wr && idx == eip_pkg::IDX_LINK_SINGLE &&
      wb[eip_pkg::SINGLE_FLAG_BIT]);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.chip_en <= eip_pkg::CHIP_EN_RESET;
      st_reg.link_en <= eip_pkg::LINK_EN_RESET;
      st_reg.single_en <= eip_pkg::SINGLE_EN_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign waitrequest = req & ~st_reg.ack;
  assign readdata = st_reg.rdata;

  // The pin only ever sinks; an external pull-up supplies the high level.
  assign irq_n_out = 1'b0;
  assign irq_n_oe_n = ~(|st_reg.chip_flag | |st_reg.link_flag |
                        st_reg.single_flag);

endmodule

// ==== hdl/eip_pkg.sv ====
// Shared constants and carrier types for the event interrupt and PRBS block.
package eip_pkg;

  // Avalon-MM byte address and data widths.
  localparam int ADDR_W = 14;
  localparam int DATA_W = 32;
  localparam int IDX_W = 12;
  localparam int REG_W = 8;

  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_CHIP_EN0 = 12'h01f;
  localparam logic [IDX_W-1:0] IDX_CHECKER_EVT_EN = 12'h020;
  localparam logic [IDX_W-1:0] IDX_CHIP_CLR0 = 12'h023;
  localparam logic [IDX_W-1:0] IDX_PRBS_CTRL = 12'h14b;
  localparam logic [IDX_W-1:0] IDX_PRBS_ERR_I = 12'h14c;
  localparam logic [IDX_W-1:0] IDX_PRBS_ERR_Q = 12'h14d;
  localparam logic [IDX_W-1:0] IDX_LINK_CLR0 = 12'h46d;
  localparam logic [IDX_W-1:0] IDX_LINK_EN = 12'h47a;
  localparam logic [IDX_W-1:0] IDX_LINK_SINGLE = 12'h47b;

  // Event block sizes, in 8-bit registers.
  localparam int CHIP_REGS = 3;
  localparam int LINK_REGS = 7;
  localparam int CHIP_EVTS = CHIP_REGS * REG_W;
  localparam int LINK_EVTS = LINK_REGS * REG_W;

  // Field positions.
  localparam int PRBS_RUN_BIT = 0;
  localparam int PRBS_CLEAR_BIT = 1;
  localparam int PRBS_SEL_BIT = 2;
  localparam int PRBS_PASS_I_BIT = 6;
  localparam int PRBS_PASS_Q_BIT = 7;
  localparam int SINGLE_EN_BIT = 3;
  localparam int SINGLE_FLAG_BIT = 4;
  localparam int FAIL_EVT_I = 8;
  localparam int FAIL_EVT_Q = 9;

  // Reset values.
  localparam logic SINGLE_EN_RESET = 1'b1;
  localparam logic [CHIP_EVTS-1:0] CHIP_EN_RESET = 24'h000000;
  localparam logic [LINK_REGS-1:0] LINK_EN_RESET = 7'h00;

  // Interpolation factors for which the checker may run.
  localparam logic [3:0] INTERP_X2 = 4'h2;
  localparam logic [3:0] INTERP_X4 = 4'h4;
  localparam logic [3:0] INTERP_X8 = 4'h8;

  // Pattern taps: x^7+x^6+1 and x^15+x^14+1.
  localparam int PRBS7_TAP_A = 7;
  localparam int PRBS7_TAP_B = 6;
  localparam int PRBS15_TAP_A = 15;
  localparam int PRBS15_TAP_B = 14;
  localparam int GROUP_W = 32;
  localparam int ERR_CNT_W = 8;

  // Host settle time before results are read, in milliseconds.
  localparam int PRBS_SETTLE_MS = 500;

  typedef struct packed {
    logic valid;
    logic [GROUP_W-1:0] i_data;
    logic [GROUP_W-1:0] q_data;
  } eip_iq_type;

  typedef struct packed {
    logic run;
    logic clear;
    logic sel15;
  } eip_prbs_cfg_type;

endpackage

// ==== hdl/eip_prbs_chk.sv ====
// One channel of the self-synchronising datapath pattern checker.
`timescale 1ns/100ps
module eip_prbs_chk #(
  parameter int GROUP_W = eip_pkg::GROUP_W,
  parameter int CNT_W = eip_pkg::ERR_CNT_W
) (
  input wire logic clock,
  input wire logic rst,
  input eip_pkg::eip_prbs_cfg_type cfg,
  input wire logic valid,
  input wire logic [GROUP_W-1:0] data,
  output logic pass,
  output logic [CNT_W-1:0] err_count
);

  localparam int HIST_W = eip_pkg::PRBS15_TAP_A;

  typedef struct packed {
    logic [HIST_W-1:0] hist;
    logic primed;
    logic pass;
    logic [CNT_W-1:0] cnt;
  } eip_chk_state_type;

  eip_chk_state_type st_reg;
  eip_chk_state_type st_next;
  logic [GROUP_W+HIST_W-1:0] seq;
  logic mismatch;
  logic expect_bit;

  // Bit 0 of each group is the oldest bit; the history holds the tail of
  // the previous group so every bit is predicted from received data.
  always_comb begin
    st_next = st_reg;
    seq = {data, st_reg.hist};
    mismatch = 1'b0;
    expect_bit = 1'b0;
    for (int k = HIST_W; k < GROUP_W + HIST_W; k++) begin
      if (cfg.sel15) begin
        expect_bit = seq[k-eip_pkg::PRBS15_TAP_A] ^
                     seq[k-eip_pkg::PRBS15_TAP_B];
      end else begin
        expect_bit = seq[k-eip_pkg::PRBS7_TAP_A] ^
                     seq[k-eip_pkg::PRBS7_TAP_B];
      end
      mismatch = mismatch | (seq[k] ^ expect_bit);
    end
    if (cfg.clear) begin
      st_next.primed = 1'b0;
      st_next.pass = 1'b1;
      st_next.cnt = '0;
    end else if (cfg.run && valid) begin
      st_next.hist = data[GROUP_W-1 -: HIST_W];
      st_next.primed = 1'b1;
      // One error at most per group, however many bits disagree.
      if (st_reg.primed && mismatch) begin
        st_next.pass = 1'b0;
        if (st_reg.cnt != {CNT_W{1'b1}}) begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.pass <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pass = st_reg.pass;
  assign err_count = st_reg.cnt;

endmodule

// ==== tb/eip_event_irq_chk.sv ====
// Port checker for the event interrupt and pattern checker block.
`timescale 1ns/100ps
module eip_event_irq_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [eip_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [eip_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic link_single_event,
  input wire logic irq_n_out,
  input wire logic irq_n_oe_n
);
  logic wr_seen_reg;
  logic done;
  assign done = (read | write) & ~waitrequest;
  // Until software first writes, the single link event keeps its reset enable.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_seen_reg <= 1'b0;
    end else if (write) begin
      wr_seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wait_one_a: assert property ((read | write) && waitrequest |=> done)
    else $error("bus answer not one cycle late");
  wait_first_a: assert property ($rose(read | write) |-> waitrequest)
    else $error("bus answered without a wait state");
  wait_idle_a: assert property (!(read | write) |-> !waitrequest)
    else $error("waitrequest high while idle");
  drive_zero_a: assert property (irq_n_out == 1'b0)
    else $error("request pin drives a high level");
  irq_hold_a: assert property (!irq_n_oe_n && !done && !$past(done) &&
    !$past(done, 2) |=> !irq_n_oe_n)
    else $error("request released without a write");
  single_evt_a: assert property ($rose(link_single_event) &&
    !wr_seen_reg |-> ##[1:3] !irq_n_oe_n)
    else $error("single link event raised no request");
  reset_rel_a: assert property ($fell(rst) |-> irq_n_oe_n)
    else $error("request active right after reset");
  rd_upper_a: assert property (read && !waitrequest |->
    readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  link_clr_a: assert property (read && !waitrequest &&
    address[13:2] inside {[12'h46d:12'h473]} |-> readdata[7:0] == 8'h00)
    else $error("link clear register read not zero");
  cover property ($fell(irq_n_oe_n));
  cover property ($rose(irq_n_oe_n));
  cover property (read && !waitrequest);
  cover property (write && !waitrequest);
endmodule
bind eip_event_irq eip_event_irq_chk chk_i (.clock(clock), .rst(rst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .link_single_event(link_single_event),
  .irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n));

// ==== tb/eip_host_pin.sv ====
// Host-side model of the shared interrupt request line and its pull-up.
`timescale 1ns/100ps
module eip_host_pin (
  input wire logic irq_n_out,
  input wire logic irq_n_oe_n,
  output logic irq_line
);
  // Released, the line floats to the pull-up level, never to the last value.
  assign irq_line = irq_n_oe_n ? 1'b1 : irq_n_out;
endmodule

// ==== tb/tb_eip_event_irq.sv ====
// Self-checking bench for the event interrupt and pattern checker block.
`timescale 1ns/100ps
module tb_eip_event_irq;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [13:0] address = 14'h0000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [23:0] chip_event = 24'h000000;
  logic [55:0] link_event = 56'h0;
  logic link_single_event = 1'b0;
  logic [3:0] interp_factor = 4'h2;
  eip_pkg::eip_iq_type iq = 65'h0;
  logic irq_n_out;
  logic irq_n_oe_n;
  logic irq_line;
  logic [14:0] hist = 15'h7fff;
  logic sel15 = 1'b0;
  int err_count = 0;
  int n_checks = 0;
  eip_event_irq uut (.clock(clock), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .chip_event(chip_event),
    .link_event(link_event), .link_single_event(link_single_event),
    .interp_factor(interp_factor), .iq(iq), .irq_n_out(irq_n_out),
    .irq_n_oe_n(irq_n_oe_n));
  eip_host_pin host (.irq_n_out(irq_n_out), .irq_n_oe_n(irq_n_oe_n),
    .irq_line(irq_line));
  initial forever #2 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("Checks %0d, errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // The request stands until a rising edge samples waitrequest low; a
  // missing answer is left to the watchdog rather than to a local limit.
  task automatic xfer(input logic wr_en, input logic [11:0] idx,
      input logic [7:0] wd, output logic [31:0] dout);
    @(posedge clock);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, wd};
    read <= ~wr_en;
    write <= wr_en;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    dout = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    xfer(1'b1, idx, wd, d);
  endtask
  task automatic rd(input logic [11:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    xfer(1'b0, idx, 8'h00, d);
    chk(d, {24'h000000, exp});
  endtask
  task automatic pin(input logic exp);
    repeat (3) @(negedge clock);
    chk({31'h0, irq_line}, {31'h0, exp});
  endtask
  // Sends one 32-bit group on both channels, bit 0 oldest; bad flips I bits.
  task automatic grp(input logic [31:0] bad);
    logic [31:0] g;
    logic nb;
    for (int k = 0; k < 32; k++) begin
      nb = sel15 ? hist[13] ^ hist[14] : hist[5] ^ hist[6];
      hist = {hist[13:0], nb};
      g[k] = nb;
    end
    @(posedge clock);
    iq <= {1'b1, g ^ bad, g};
    @(posedge clock);
    iq.valid <= 1'b0;
  endtask
  initial begin
    #50000;
    err_count++;
    results();
  end
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(12'h47b, 8'h08);
    rd(12'h01f, 8'h00);
    rd(12'h100, 8'h00);
    pin(1'b1);
    @(posedge clock) link_single_event <= 1'b1;
    pin(1'b0);
    rd(12'h47b, 8'h18);
    wr(12'h47b, 8'h18);
    rd(12'h47b, 8'h08);
    pin(1'b1);
    wr(12'h47b, 8'h00);
    rd(12'h47b, 8'h00);
    @(posedge clock) chip_event <= 24'h0000a5;
    rd(12'h023, 8'ha5);
    @(posedge clock) chip_event <= 24'h00005a;
    rd(12'h023, 8'h5a);
    wr(12'h01f, 8'hff);
    rd(12'h01f, 8'hff);
    byteenable <= 4'h0;
    wr(12'h01f, 8'h00);
    byteenable <= 4'hf;
    rd(12'h01f, 8'hff);
    rd(12'h023, 8'h00);
    @(posedge clock) chip_event <= 24'h00005b;
    pin(1'b0);
    @(posedge clock) chip_event <= 24'h00005a;
    rd(12'h023, 8'h01);
    wr(12'h01f, 8'h00);
    rd(12'h023, 8'h5a);
    pin(1'b1);
    wr(12'h01f, 8'hff);
    @(posedge clock) chip_event <= 24'h00005b;
    wr(12'h023, 8'h02);
    rd(12'h023, 8'h01);
    wr(12'h023, 8'h01);
    rd(12'h023, 8'h00);
    wr(12'h47a, 8'h01);
    @(posedge clock) link_event <= 56'h108;
    rd(12'h47a, 8'h01);
    rd(12'h46d, 8'h00);
    pin(1'b0);
    wr(12'h46d, 8'h08);
    rd(12'h47a, 8'h00);
    pin(1'b1);
    wr(12'h020, 8'h03);
    interp_factor <= 4'h1;
    wr(12'h14b, 8'h03);
    wr(12'h14b, 8'h01);
    repeat (3) grp(32'hffc00000);
    rd(12'h14c, 8'h00);
    interp_factor <= 4'h8;
    sel15 = 1'b1;
    wr(12'h14b, 8'h07);
    wr(12'h14b, 8'h05);
    repeat (4) grp(32'h00000000);
    rd(12'h14b, 8'hc5);
    rd(12'h14c, 8'h00);
    interp_factor <= 4'h4;
    sel15 = 1'b0;
    wr(12'h14b, 8'h03);
    wr(12'h14b, 8'h01);
    repeat (3) grp(32'h00000000);
    grp(32'hffc00000);
    repeat (3) grp(32'h00000000);
    rd(12'h14b, 8'h81);
    rd(12'h14c, 8'h02);
    rd(12'h14d, 8'h00);
    rd(12'h024, 8'h01);
    pin(1'b0);
    results();
  end
endmodule
